// [rtl/gpio_pkg.sv]
// package for the general purpose adapter user port: word width, pulse timing
// assumes a single 100 MHz clock shared by the adapter end and the user end
package gpio_pkg;
  localparam int WORD_W        = 36;
  localparam int CTRL_W        = 8;
  localparam int STAT_W        = 8;
  localparam int LEVEL_W       = 4;
  localparam int CLK_NS        = 10;
  localparam int PULSE_NS      = 100;
  localparam int SETUP_NS      = 400;
  localparam int GAP_NS        = 1000;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC       = GAP_NS / CLK_NS;
  localparam int FIFO_DEPTH    = 16;
  localparam int CNT_W         = 8;
endpackage

// [rtl/gpio_link_if.sv]
// interface joining the adapter end to the user end
// assumes both ends run on the same clock; all signals active high
`timescale 1ns/1ns
`default_nettype none
interface gpio_link_if;
  logic [gpio_pkg::WORD_W-1:0]  input_word_lines;
  logic [gpio_pkg::WORD_W-1:0]  output_word_lines;
  logic [gpio_pkg::STAT_W-1:0]  status_set_lines;
  logic [gpio_pkg::LEVEL_W-1:0] status_level_lines;
  logic [gpio_pkg::CTRL_W-1:0]  control_state_lines;
  logic                         control_clear_pulse;
  logic                         control_load_pulse;
  logic                         data_clear_pulse;
  logic                         data_load_pulse;
  logic                         input_done_pulse;
  logic                         system_reset_pulse;
  modport adapter (
    input  input_word_lines, status_set_lines, status_level_lines,
    output output_word_lines, control_state_lines, control_clear_pulse,
    output control_load_pulse, data_clear_pulse, data_load_pulse,
    output input_done_pulse, system_reset_pulse
  );
  modport user (
    output input_word_lines, status_set_lines, status_level_lines,
    input  output_word_lines, control_state_lines, control_clear_pulse,
    input  control_load_pulse, data_clear_pulse, data_load_pulse,
    input  input_done_pulse, system_reset_pulse
  );
endinterface
`default_nettype wire

// [rtl/gpio_adapter.sv]
// adapter end: takes host instructions, regenerates the clear/load pulse pairs,
// holds control and status flip-flops, samples the user's input word.
// assumes host command strobes come from logic on clk; link inputs from user logic
// are treated as foreign and pass two flip-flops.
`timescale 1ns/1ns
`default_nettype none
module gpio_adapter (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  gpio_link_if.adapter                     link,
  input  wire logic                        host_bus_reset,
  input  wire logic                        control_output_instruction,
  input  wire logic                        data_output_instruction,
  input  wire logic                        data_input_instruction,
  input  wire logic                        status_input_instruction,
  input  wire logic [gpio_pkg::WORD_W-1:0] host_word,
  output logic                             host_busy,
  output logic [gpio_pkg::WORD_W-1:0]      host_read_word,
  output logic                             host_read_valid
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {
    GPIO_IDLE, GPIO_SETUP, GPIO_CLR, GPIO_GAP, GPIO_LOAD, GPIO_RST
  } gpio_phase_t;

  typedef struct packed {
    gpio_phase_t                   phase;
    logic                          is_ctrl;
    logic                          with_reset;
    logic [gpio_pkg::CNT_W-1:0]    cnt;
    logic [gpio_pkg::WORD_W-1:0]   out_word;
    logic [gpio_pkg::CTRL_W-1:0]   ctrl;
    logic [gpio_pkg::STAT_W-1:0]   stat;
    logic [gpio_pkg::STAT_W-1:0]   set_s1;
    logic [gpio_pkg::STAT_W-1:0]   set_s2;
    logic [gpio_pkg::STAT_W-1:0]   set_prev;
    logic [gpio_pkg::LEVEL_W-1:0]  lvl_s1;
    logic [gpio_pkg::LEVEL_W-1:0]  lvl_s2;
    logic [gpio_pkg::WORD_W-1:0]   in_s1;
    logic [gpio_pkg::WORD_W-1:0]   in_s2;
    logic [gpio_pkg::WORD_W-1:0]   rd_word;
    logic                          rd_valid;
    logic [gpio_pkg::CNT_W-1:0]    done_cnt;
    logic                          pwr_up;
  } gpio_adapter_state_t;

  gpio_adapter_state_t s_q;
  gpio_adapter_state_t s_d;

  function automatic logic [gpio_pkg::CNT_W-1:0] gpio_cyc(input int n);
    return gpio_pkg::CNT_W'(n - 1);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;
    s_d.set_s1   = link.status_set_lines;
    s_d.set_s2   = s_q.set_s1;
    s_d.set_prev = s_q.set_s2;
    s_d.lvl_s1   = link.status_level_lines;
    s_d.lvl_s2   = s_q.lvl_s1;
    s_d.in_s1    = link.input_word_lines;
    s_d.in_s2    = s_q.in_s1;
    // a rising edge of a set line sets its bit; an idle low line does nothing
    s_d.stat     = s_q.stat | (s_q.set_s2 & ~s_q.set_prev);
    if (s_q.done_cnt != '0) begin
      s_d.done_cnt = s_q.done_cnt - 1'b1;
    end
    if (data_input_instruction && s_q.phase != GPIO_RST) begin
      s_d.rd_word  = s_q.in_s2;
      s_d.rd_valid = 1'b1;
      s_d.done_cnt = gpio_pkg::CNT_W'(gpio_pkg::PULSE_CYC);
    end else if (status_input_instruction) begin
      s_d.rd_word  = '0;
      s_d.rd_word[gpio_pkg::CTRL_W-1:0] = s_q.ctrl;
      s_d.rd_word[gpio_pkg::CTRL_W +: gpio_pkg::STAT_W] = s_q.stat;
      s_d.rd_word[gpio_pkg::CTRL_W+gpio_pkg::STAT_W +: gpio_pkg::LEVEL_W] = s_q.lvl_s2;
      s_d.rd_valid = 1'b1;
    end
    case (s_q.phase)
      GPIO_IDLE: begin
        if (host_bus_reset || s_q.pwr_up) begin
          s_d.pwr_up = 1'b0;
          s_d.phase  = GPIO_RST;
          s_d.cnt    = gpio_cyc(gpio_pkg::PULSE_CYC);
        end else if (control_output_instruction || data_output_instruction) begin
          s_d.is_ctrl  = control_output_instruction;
          s_d.out_word = host_word;
          s_d.phase    = GPIO_SETUP;
          s_d.cnt      = gpio_cyc(gpio_pkg::SETUP_CYC);
        end
      end
      GPIO_SETUP: begin
        if (s_q.cnt == '0) begin
          s_d.phase = GPIO_CLR;
          s_d.cnt   = gpio_cyc(gpio_pkg::PULSE_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      GPIO_RST: begin
        // the reset pulse drags a control clear with it
        s_d.ctrl = '0;
        s_d.stat = '0;
        if (s_q.cnt == '0) begin
          s_d.phase = GPIO_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      GPIO_CLR: begin
        if (s_q.is_ctrl) begin
          s_d.ctrl = '0;
        end
        if (s_q.cnt == '0) begin
          s_d.phase = GPIO_GAP;
          s_d.cnt   = gpio_cyc(gpio_pkg::GAP_CYC - gpio_pkg::PULSE_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      GPIO_GAP: begin
        if (s_q.cnt == '0) begin
          s_d.phase = GPIO_LOAD;
          s_d.cnt   = gpio_cyc(gpio_pkg::PULSE_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      GPIO_LOAD: begin
        if (s_q.is_ctrl) begin
          s_d.ctrl = s_q.out_word[gpio_pkg::CTRL_W-1:0];
        end
        if (s_q.cnt == '0) begin
          s_d.phase = GPIO_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: s_d.phase = GPIO_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q        <= '0;
      s_q.phase  <= GPIO_IDLE;
      s_q.pwr_up <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  wire logic clr_now  = (s_q.phase == GPIO_CLR);
  wire logic load_now = (s_q.phase == GPIO_LOAD);
  wire logic rst_now  = (s_q.phase == GPIO_RST);

  assign link.output_word_lines   = s_q.out_word;
  assign link.control_state_lines = s_q.ctrl;
  assign link.control_clear_pulse = (clr_now && s_q.is_ctrl) || rst_now;
  assign link.control_load_pulse  = load_now && s_q.is_ctrl;
  assign link.data_clear_pulse    = clr_now && !s_q.is_ctrl;
  assign link.data_load_pulse     = load_now && !s_q.is_ctrl;
  assign link.input_done_pulse    = (s_q.done_cnt != '0);
  assign link.system_reset_pulse  = rst_now;
  assign host_busy                = (s_q.phase != GPIO_IDLE) || s_q.pwr_up;
  assign host_read_word           = s_q.rd_word;
  assign host_read_valid          = s_q.rd_valid;
endmodule
`default_nettype wire

// [rtl/gpio_fifo.sv]
// plain synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty are exact
`timescale 1ns/1ns
`default_nettype none
module gpio_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } gpio_fifo_state_t;
  gpio_fifo_state_t s_q;
  gpio_fifo_state_t s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem_q[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[s_q.wp] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [rtl/gpio_user.sv]
// user end: edge-detects each adapter pulse, keeps a data register that is
// cleared and loaded by the data pulse pair, and queues loaded words in a fifo
// assumes the adapter pulses are foreign and pass two flip-flops
`timescale 1ns/1ns
`default_nettype none
module gpio_user (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  gpio_link_if.user                        link,
  input  wire logic [gpio_pkg::WORD_W-1:0] user_input_word,
  input  wire logic [gpio_pkg::STAT_W-1:0] user_status_set,
  input  wire logic [gpio_pkg::LEVEL_W-1:0] user_status_level,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic [gpio_pkg::WORD_W-1:0]      out_word,
  output logic [gpio_pkg::WORD_W-1:0]      data_reg,
  output logic [gpio_pkg::CTRL_W-1:0]      control_seen,
  output logic                             input_taken,
  output logic                             control_event,
  output logic                             overrun
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [5:0]                  p_s1;
    logic [5:0]                  p_s2;
    logic [5:0]                  p_prev;
    logic [gpio_pkg::CTRL_W-1:0] c_s1;
    logic [gpio_pkg::CTRL_W-1:0] c_s2;
    logic [gpio_pkg::WORD_W-1:0] w_s1;
    logic [gpio_pkg::WORD_W-1:0] w_s2;
    logic [gpio_pkg::WORD_W-1:0] data;
    logic                        push;
    logic                        taken;
    logic                        ctl_ev;
    logic                        ovr;
    logic [gpio_pkg::STAT_W-1:0] set_out;
    logic [gpio_pkg::LEVEL_W-1:0] lvl_out;
    logic [gpio_pkg::WORD_W-1:0] in_out;
  } gpio_user_state_t;
  gpio_user_state_t s_q;
  gpio_user_state_t s_d;
  logic [5:0] rise;
  logic       fifo_ready;

  always_comb begin
    s_d        = s_q;
    s_d.p_s1   = {link.system_reset_pulse, link.input_done_pulse, link.data_load_pulse,
                  link.data_clear_pulse, link.control_load_pulse, link.control_clear_pulse};
    s_d.p_s2   = s_q.p_s1;
    s_d.p_prev = s_q.p_s2;
    s_d.c_s1   = link.control_state_lines;
    s_d.c_s2   = s_q.c_s1;
    // the word is foreign too; it settles long before the load pulse reaches us
    s_d.w_s1   = link.output_word_lines;
    s_d.w_s2   = s_q.w_s1;
    rise       = s_q.p_s2 & ~s_q.p_prev;
    s_d.push   = 1'b0;
    s_d.taken  = rise[4];
    s_d.ctl_ev = rise[0] | rise[1];
    s_d.in_out  = user_input_word;
    s_d.set_out = user_status_set;
    s_d.lvl_out = user_status_level;
    if (rise[2]) begin
      s_d.data = '0;
    end
    if (rise[3]) begin
      s_d.data = s_q.data | s_q.w_s2;
      if (fifo_ready) begin
        s_d.push = 1'b1;
      end else begin
        s_d.ovr = 1'b1;
      end
    end
    if (rise[5]) begin
      s_d.data = '0;
      s_d.ovr  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // words are queued after load so the user can drain at its own pace
  gpio_fifo #(
    .WIDTH (gpio_pkg::WORD_W),
    .DEPTH (gpio_pkg::FIFO_DEPTH)
  ) i_gpio_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (s_q.push),
    .in_ready  (fifo_ready),
    .in_data   (s_q.data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_word)
  );

  assign link.input_word_lines   = s_q.in_out;
  assign link.status_set_lines   = s_q.set_out;
  assign link.status_level_lines = s_q.lvl_out;
  assign data_reg                = s_q.data;
  assign control_seen            = s_q.c_s2;
  assign input_taken             = s_q.taken;
  assign control_event           = s_q.ctl_ev;
  assign overrun                 = s_q.ovr;
endmodule
`default_nettype wire

// [verification/gpio_link_properties.sv]
// checker for the link between adapter end and user end
// assumes one clock for both ends; instantiated beside the link interface
`timescale 1ns/1ns
`default_nettype none
module gpio_link_properties (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic [gpio_pkg::WORD_W-1:0] output_word_lines,
  input wire logic [gpio_pkg::CTRL_W-1:0] control_state_lines,
  input wire logic                        control_clear_pulse,
  input wire logic                        control_load_pulse,
  input wire logic                        data_clear_pulse,
  input wire logic                        data_load_pulse,
  input wire logic                        input_done_pulse,
  input wire logic                        system_reset_pulse
);
  // the age counter reads one less than the cycles the word has stood
  localparam logic [7:0] SETUP_MIN = 8'(gpio_pkg::SETUP_CYC - 1);
  logic [7:0]                  stable_q;
  logic [gpio_pkg::WORD_W-1:0] word_q;
  // ****
  // age of the output word
  // ****
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stable_q <= 8'h00;
      word_q   <= '0;
    end else begin
      word_q <= output_word_lines;
      if (word_q != output_word_lines) begin
        stable_q <= 8'h00;
      end else if (stable_q != 8'hff) begin
        stable_q <= stable_q + 8'h01;
      end
    end
  end
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ctrl_pair_gap: assert property (
    $rose(control_clear_pulse) && !system_reset_pulse |-> ##100 $rose(control_load_pulse))
    else $error("control load not 1 us after clear");
  a_data_pair_gap: assert property (
    $rose(data_clear_pulse) |-> ##100 $rose(data_load_pulse))
    else $error("data load not 1 us after clear");
  a_data_load_width: assert property (
    $rose(data_load_pulse) |-> ##9 data_load_pulse ##1 !data_load_pulse)
    else $error("data load pulse width");
  a_done_width: assert property (
    $rose(input_done_pulse) |-> ##9 input_done_pulse ##1 !input_done_pulse)
    else $error("input done pulse width");
  a_reset_width: assert property (
    $rose(system_reset_pulse) |-> ##9 system_reset_pulse ##1 !system_reset_pulse)
    else $error("reset pulse width");
  a_reset_has_clear: assert property (
    system_reset_pulse |-> control_clear_pulse)
    else $error("reset pulse without control clear");
  a_word_setup: assert property (
    ($rose(control_clear_pulse) && !system_reset_pulse) || $rose(data_clear_pulse)
    || $rose(control_load_pulse) || $rose(data_load_pulse) |-> stable_q >= SETUP_MIN)
    else $error("output word not settled before pulse");
  a_ctrl_load_word: assert property (
    $rose(control_load_pulse) |-> ##[0:10] control_state_lines == output_word_lines[7:0])
    else $error("control lines miss loaded word");
  a_ctrl_cleared: assert property (
    $rose(control_clear_pulse) |-> ##[0:10] control_state_lines == 8'h00)
    else $error("control lines not cleared");
  a_ctrl_steady: assert property (
    $changed(control_state_lines) |-> control_clear_pulse || control_load_pulse
    || $past(control_clear_pulse) || $past(control_load_pulse))
    else $error("control lines moved without pulse");
endmodule
`default_nettype wire

// [verification/general_purpose_io_port_user_side_tb_top.sv]
// testbench: adapter end and user end joined by the link interface
// assumes a 100 MHz clock; host strobes and user inputs driven at rising edges
`timescale 1ns/1ns
`default_nettype none
module general_purpose_io_port_user_side_tb_top;
  localparam int W = gpio_pkg::WORD_W;
  logic                              clk;
  logic                              nrst;
  logic                              host_bus_reset;
  logic [3:0]                        cmd;
  logic [W-1:0]                      host_word;
  logic                              host_busy;
  logic [W-1:0]                      host_read_word;
  logic                              host_read_valid;
  logic [W-1:0]                      user_input_word;
  logic [gpio_pkg::STAT_W-1:0]       user_status_set;
  logic [gpio_pkg::LEVEL_W-1:0]      user_status_level;
  logic                              out_valid;
  logic                              out_ready;
  logic [W-1:0]                      out_word;
  logic [W-1:0]                      data_reg;
  logic [gpio_pkg::CTRL_W-1:0]       control_seen;
  logic                              input_taken;
  logic                              control_event;
  logic                              overrun;
  int                                error_cnt;
  int                                checks_done;
  gpio_link_if link();
  gpio_adapter i_gpio_adapter (.clk, .nrst, .link, .host_bus_reset,
    .control_output_instruction(cmd[0]), .data_output_instruction(cmd[1]),
    .data_input_instruction(cmd[2]), .status_input_instruction(cmd[3]),
    .host_word, .host_busy, .host_read_word, .host_read_valid);
  gpio_user i_gpio_user (.clk, .nrst, .link, .user_input_word, .user_status_set,
    .user_status_level, .out_valid, .out_ready, .out_word, .data_reg,
    .control_seen, .input_taken, .control_event, .overrun);
  gpio_link_properties i_gpio_link_properties (.clk, .nrst,
    .output_word_lines(link.output_word_lines),
    .control_state_lines(link.control_state_lines),
    .control_clear_pulse(link.control_clear_pulse),
    .control_load_pulse(link.control_load_pulse),
    .data_clear_pulse(link.data_clear_pulse), .data_load_pulse(link.data_load_pulse),
    .input_done_pulse(link.input_done_pulse),
    .system_reset_pulse(link.system_reset_pulse));
  // ****
  // helpers
  // ****
  task automatic chk_w(input logic [W-1:0] got, input logic [W-1:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp, input string m);
    chk_w(W'(got), W'(exp), m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 400 && host_busy !== 1'b0; n++) tick(1);
    chk_b(host_busy, 1'b0, "busy stuck");
  endtask
  // strobe k: 0 control out, 1 data out, 2 data in, 3 status in
  task automatic issue(input int k, input logic [W-1:0] w);
    wait_idle();
    @(posedge clk);
    cmd[k]    <= 1'b1;
    host_word <= w;
    @(posedge clk);
    cmd <= 4'h0;
    #1;
  endtask
  function automatic logic [W-1:0] dw(input int i);
    return {9{4'(i)}} ^ {W{i[0]}};
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_power_up();
    int r;
    int c;
    r = 0;
    c = 0;
    repeat (12) begin
      tick(1);
      r += link.system_reset_pulse;
      c += link.control_clear_pulse;
    end
    chk_w(W'(r), W'(10), "reset pulse length");
    chk_w(W'(c), W'(10), "clear with reset");
    $display("t_power_up done");
  endtask
  task automatic t_control();
    int n;
    issue(0, 36'h0_0000_00a5);
    // a second strobe while busy must be dropped
    @(posedge clk);
    cmd[0]    <= 1'b1;
    host_word <= 36'h0_0000_005a;
    @(posedge clk);
    cmd <= 4'h0;
    n = 0;
    repeat (200) begin
      tick(1);
      n += control_event;
    end
    chk_w(W'(n), W'(2), "user control events");
    wait_idle();
    tick(4);
    chk_w(W'(link.control_state_lines), 36'h0a5, "control lines");
    chk_w(W'(control_seen), 36'h0a5, "user control copy");
    issue(0, 36'h0_0000_003c);
    issue(3, '0);
    chk_w(W'(host_read_word[7:0]), 36'h03c, "control in status word");
    $display("t_control done");
  endtask
  task automatic t_data_in();
    bit seen;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      user_input_word <= p ? 36'h0 : 36'h9_a5c3_0f1e;
      tick(6);
      issue(2, '0);
      chk_b(host_read_valid, 1'b1, "read valid");
      chk_w(host_read_word, p ? 36'h0 : 36'h9_a5c3_0f1e, "input word");
      chk_b(link.input_done_pulse, 1'b1, "input done");
      seen = 0;
      repeat (6) begin
        tick(1);
        seen |= input_taken;
      end
      chk_b(seen, 1'b1, "user saw done");
    end
    $display("t_data_in done");
  endtask
  task automatic t_status();
    @(posedge clk);
    user_status_level <= 4'h9;
    tick(45);
    issue(3, '0);
    chk_w(W'(host_read_word[19:8]), 36'h900, "idle status");
    @(posedge clk);
    user_status_set <= 8'h81;
    repeat (10) @(posedge clk);
    user_status_set <= 8'h00;
    tick(5);
    issue(3, '0);
    chk_w(W'(host_read_word[19:8]), 36'h981, "status set");
    $display("t_status done");
  endtask
  task automatic t_data_out();
    @(posedge clk);
    out_ready <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      issue(1, dw(i));
      wait_idle();
      tick(3);
      chk_w(data_reg, dw(i), "data register");
    end
    chk_b(overrun, 1'b1, "overrun");
    for (int i = 0; i < 16; i++) begin
      chk_b(out_valid, 1'b1, "fifo valid");
      chk_w(out_word, dw(i), "fifo word");
      @(posedge clk);
      out_ready <= 1'b1;
      @(posedge clk);
      out_ready <= 1'b0;
      tick(2);
    end
    chk_b(out_valid, 1'b0, "fifo empty");
    $display("t_data_out done");
  endtask
  task automatic t_bus_reset();
    bit seen;
    seen = 0;
    @(posedge clk);
    host_bus_reset <= 1'b1;
    @(posedge clk);
    host_bus_reset <= 1'b0;
    repeat (5) begin
      tick(1);
      seen |= link.system_reset_pulse;
    end
    chk_b(seen, 1'b1, "bus reset pulse");
    wait_idle();
    tick(4);
    chk_w(W'(link.control_state_lines), '0, "control after reset");
    chk_b(overrun, 1'b0, "overrun after reset");
    issue(3, '0);
    chk_w(W'(host_read_word[15:0]), '0, "status after reset");
    $display("t_bus_reset done");
  endtask
  // ****
  // clock, sequence and watchdog
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst              = 1'b0;
    host_bus_reset    = 1'b0;
    cmd               = 4'h0;
    host_word         = '0;
    user_input_word   = '0;
    user_status_set   = 8'h00;
    user_status_level = 4'h0;
    out_ready         = 1'b0;
    error_cnt         = 0;
    checks_done       = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_power_up();
    t_control();
    t_data_in();
    t_status();
    t_data_out();
    t_bus_reset();
    test_done();
  end
  // whole run is about 3200 cycles; six times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
